//--- spdif_lock_pkg.sv
// shared constants, types and helpers for the receiver lock and control block
package spdif_lock_pkg;

	// ------------------------------------------------------------------
	// clock and line timing
	// ------------------------------------------------------------------
	localparam int unsigned CLOCK_HZ       = 100_000_000;
	localparam int unsigned SAMPLE_RATE_HZ = 48_000;
	localparam int unsigned UI_PER_FRAME   = 128;
	localparam int unsigned UI_CYC         =
		CLOCK_HZ / (SAMPLE_RATE_HZ * UI_PER_FRAME);

	localparam int          IV_W    = 8;
	localparam logic [IV_W-1:0] IV_MIN  = IV_W'(UI_CYC / 2);
	localparam logic [IV_W-1:0] IV1_MAX = IV_W'((UI_CYC * 3) / 2);
	localparam logic [IV_W-1:0] IV2_MAX = IV_W'((UI_CYC * 5) / 2);
	localparam logic [IV_W-1:0] IV3_MAX = IV_W'((UI_CYC * 7) / 2);
	localparam logic [IV_W-1:0] IV_ONE  = 8'h01;

	// interval classes, in unit intervals
	localparam logic [1:0] CLS_BAD = 2'h0;
	localparam logic [1:0] CLS_1UI = 2'h1;
	localparam logic [1:0] CLS_2UI = 2'h2;
	localparam logic [1:0] CLS_3UI = 2'h3;

	// subframe layout
	localparam logic [3:0] PRE_UI_TOTAL = 4'h8;
	localparam logic [4:0] SF_BITS_LAST = 5'h1B;
	localparam int         SF_W         = 28;
	localparam int         AUDIO_W      = 24;
	localparam int         SF_CS_POS    = 26;
	localparam logic [7:0] CS_WLEN_LO   = 8'h20;
	localparam logic [7:0] CS_WLEN_HI   = 8'h23;
	localparam logic [7:0] CS_IDX_MAX   = 8'hFF;

	// lock qualification
	localparam int         LOCK_W      = 7;
	localparam logic [LOCK_W-1:0] LOCK_NORMAL = 7'h40;
	localparam logic [LOCK_W-1:0] LOCK_FAST   = 7'h08;
	localparam int         FCLK_W      = 16;

	// ------------------------------------------------------------------
	// register map: printed offsets are indices, byte address is 4x
	// ------------------------------------------------------------------
	localparam int         ADDR_W        = 18;
	localparam logic [15:0] IDX_LOCK     = 16'hF600;
	localparam logic [15:0] IDX_CTRL     = 16'hF601;
	localparam logic [15:0] IDX_RESTART  = 16'hF610;
	localparam logic [15:0] IDX_IRQ_STAT = 16'hF611;
	localparam logic [15:0] IDX_IRQ_MASK = 16'hF612;

	localparam int         LOCK_BIT      = 0;
	localparam int         CTRL_W        = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam int         RST_GO_BIT    = 0;
	localparam int         RST_AUTO_BIT  = 1;
	localparam int         RST_LOST_BIT  = 2;
	localparam int         IRQ_W         = 2;
	localparam int         IRQ_GAIN_BIT  = 0;
	localparam int         IRQ_LOSS_BIT  = 1;

	typedef enum logic [1:0] {
		WLEN_24   = 2'h0,
		WLEN_20   = 2'h1,
		WLEN_16   = 2'h2,
		WLEN_AUTO = 2'h3
	} wlen_e;

	// field order matches the control register, bit 3 down to bit 0
	typedef struct packed {
		logic  fast_acquire_select;
		logic  loss_behaviour_select;
		wlen_e word_length_select;
	} ctrl_s;

	typedef struct packed {
		logic [AUDIO_W-1:0] audio;
		logic               left;
		logic               block_start;
		logic               chan_stat;
	} subframe_s;

	// word length from the four channel-status bits, bit 0 = 24-bit max
	function automatic wlen_e cs_wlen(input logic [3:0] f);
		if (f == 4'h2)
			cs_wlen = WLEN_16;
		else if (f[0])
			cs_wlen = WLEN_24;
		else
			cs_wlen = WLEN_20;
	endfunction

endpackage

//--- lock_qualifier.sv
// counts consecutive good samples and tracks the lock state
`timescale 1ns/1ps
module lock_qualifier
	import spdif_lock_pkg::*;
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic sample_ok,
	input  wire logic sample_bad,
	input  wire logic fast,
	output logic      locked,
	output logic      gained,
	output logic      lost
);
	logic [LOCK_W-1:0] count_q;
	logic [LOCK_W-1:0] target;
	logic              locked_q;
	logic              locked_d;
	logic              gained_q;
	logic              lost_q;

	assign target = fast ? LOCK_FAST : LOCK_NORMAL;

	always_comb begin
		locked_d = locked_q;
		if (sample_bad)
			locked_d = 1'b0;
		else if (sample_ok && !locked_q && (count_q + IV_ONE[LOCK_W-1:0]) >= target)
			locked_d = 1'b1;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			count_q <= '0;
		else if (sample_bad)
			count_q <= '0;
		else if (sample_ok && !locked_q)
			count_q <= count_q + IV_ONE[LOCK_W-1:0];
		else if (locked_q)
			count_q <= '0;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			locked_q <= 1'b0;
			gained_q <= 1'b0;
			lost_q   <= 1'b0;
		end else begin
			locked_q <= locked_d;
			gained_q <= locked_d & ~locked_q;
			lost_q   <= ~locked_d & locked_q;
		end
	end

	assign locked = locked_q;
	assign gained = gained_q;
	assign lost   = lost_q;
endmodule

//--- frame_clock_gen.sv
// recovered frame clock with flywheel or stop behaviour on loss of lock
`timescale 1ns/1ps
module frame_clock_gen
	import spdif_lock_pkg::*;
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic locked,
	input  wire logic stop_on_loss,
	input  wire logic sf_start,
	input  wire logic sf_left,
	output logic      fclk
);
	logic [FCLK_W-1:0] cnt_q;
	logic [FCLK_W-1:0] period_q;
	logic              have_period_q;
	logic              fclk_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_q         <= '0;
			period_q      <= '0;
			have_period_q <= 1'b0;
		end else if (locked && sf_start) begin
			period_q      <= cnt_q;
			have_period_q <= 1'b1;
			cnt_q         <= '0;
		end else if (!locked && cnt_q >= period_q) begin
			cnt_q <= '0;
		end else if (cnt_q != {FCLK_W{1'b1}}) begin
			cnt_q <= cnt_q + FCLK_W'(1);
		end
	end

	// strong mode keeps the last half-frame period running; the edges may
	// drift from the source, which is the corruption the user accepts
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			fclk_q <= 1'b0;
		else if (locked) begin
			if (sf_start)
				fclk_q <= sf_left;
		end else if (stop_on_loss || !have_period_q)
			fclk_q <= 1'b0;
		else if (cnt_q >= period_q)
			fclk_q <= ~fclk_q;
	end

	assign fclk = fclk_q;
endmodule

//--- spdif_rx_lock.sv
// biphase front end, lock control, register slave and audio output
`timescale 1ns/1ps
module spdif_rx_lock
	import spdif_lock_pkg::*;
(
	input  wire logic               CLOCK,
	input  wire logic               RESETN,
	input  wire logic [ADDR_W-1:0]  AVS_ADDRESS,
	input  wire logic               AVS_READ,
	input  wire logic               AVS_WRITE,
	input  wire logic [31:0]        AVS_WRITEDATA,
	input  wire logic [3:0]         AVS_BYTEENABLE,
	output logic      [31:0]        AVS_READDATA,
	output logic                    AVS_WAITREQUEST,
	input  wire logic               SPDIF_IN,
	output logic                    FRAME_CLK,
	output logic      [AUDIO_W-1:0] AUDIO_DATA,
	output logic                    AUDIO_LEFT,
	output logic                    AUDIO_STROBE,
	output logic                    AUDIO_MUTE,
	output logic      [1:0]         WORD_LENGTH,
	output logic                    IRQ
);
	typedef enum {HUNT, PREAMBLE, DATA_BITS} dec_state_e;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [1:0] iv_class(input logic [IV_W-1:0] n);
		if (n < IV_MIN)
			iv_class = CLS_BAD;
		else if (n <= IV1_MAX)
			iv_class = CLS_1UI;
		else if (n <= IV2_MAX)
			iv_class = CLS_2UI;
		else if (n <= IV3_MAX)
			iv_class = CLS_3UI;
		else
			iv_class = CLS_BAD;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [15:0] idx);
		hit = (a == {idx, 2'h0});
	endfunction

	function automatic logic [AUDIO_W-1:0] trim(input logic [AUDIO_W-1:0] s,
		input wlen_e w);
		case (w)
			WLEN_20: trim = {s[AUDIO_W-1:4], 4'h0};
			WLEN_16: trim = {s[AUDIO_W-1:8], 8'h00};
			default: trim = s;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// input synchroniser and edge detect
	// ------------------------------------------------------------------
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic level_q;
	logic line_edge;

	// a change counts only once the second and third stages agree
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			sync1_q <= SPDIF_IN;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q)
				level_q <= sync3_q;
		end
	end

	assign line_edge = (sync2_q == sync3_q) && (sync3_q != level_q);

	// ------------------------------------------------------------------
	// interval timer
	// ------------------------------------------------------------------
	logic [IV_W-1:0] iv_q;
	logic [1:0]      cls;
	logic            iv_timeout;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			iv_q <= '0;
		else if (line_edge)
			iv_q <= IV_ONE;
		else if (iv_q <= IV3_MAX)
			iv_q <= iv_q + IV_ONE;
	end

	assign cls        = iv_class(iv_q);
	assign iv_timeout = !line_edge && (iv_q == IV3_MAX);

	// ------------------------------------------------------------------
	// subframe decoder
	// ------------------------------------------------------------------
	dec_state_e      state_q;
	logic [3:0]      pre_sum_q;
	logic [3:0]      pre_sum_d;
	logic            pre_first_q;
	logic            pre_type_q;
	logic            left_q;
	logic            block_q;
	logic            half_q;
	logic [4:0]      bit_idx_q;
	logic [SF_W-1:0] data_q;
	logic [SF_W-1:0] data_d;
	logic            sf_ok_q;
	logic            sf_bad_q;
	logic            sf_start_q;
	subframe_s       sf_q;

	assign pre_sum_d = pre_sum_q + {2'h0, cls};
	assign data_d    = {(cls == CLS_1UI), data_q[SF_W-1:1]};

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state_q     <= HUNT;
			pre_sum_q   <= '0;
			pre_first_q <= 1'b0;
			pre_type_q  <= 1'b0;
			left_q      <= 1'b0;
			block_q     <= 1'b0;
			half_q      <= 1'b0;
			bit_idx_q   <= '0;
			data_q      <= '0;
			sf_ok_q     <= 1'b0;
			sf_bad_q    <= 1'b0;
			sf_start_q  <= 1'b0;
			sf_q        <= '0;
		end else begin
			sf_ok_q    <= 1'b0;
			sf_bad_q   <= 1'b0;
			sf_start_q <= 1'b0;
			case (state_q)
				HUNT: begin
					if (line_edge && cls == CLS_3UI) begin
						state_q     <= PREAMBLE;
						pre_sum_q   <= {2'h0, CLS_3UI};
						pre_first_q <= 1'b0;
						pre_type_q  <= 1'b1;
					end
				end
				PREAMBLE: begin
					if (iv_timeout) begin
						state_q  <= HUNT;
						sf_bad_q <= 1'b1;
					end else if (line_edge) begin
						if (cls == CLS_BAD || pre_sum_d > PRE_UI_TOTAL ||
							(pre_first_q && cls != CLS_3UI)) begin
							state_q  <= HUNT;
							sf_bad_q <= 1'b1;
						end else begin
							pre_first_q <= 1'b0;
							pre_sum_q   <= pre_sum_d;
							if (!pre_first_q && pre_type_q) begin
								// 3-1: block start, 3-3: left, 3-2: right
								pre_type_q <= 1'b0;
								left_q     <= (cls != CLS_2UI);
								block_q    <= (cls == CLS_1UI);
							end else if (pre_first_q)
								pre_type_q <= 1'b1;
							if (pre_sum_d == PRE_UI_TOTAL) begin
								state_q    <= DATA_BITS;
								bit_idx_q  <= '0;
								half_q     <= 1'b0;
								sf_start_q <= 1'b1;
							end
						end
					end
				end
				DATA_BITS: begin
					if (iv_timeout) begin
						state_q  <= HUNT;
						sf_bad_q <= 1'b1;
					end else if (line_edge) begin
						if (cls == CLS_BAD || cls == CLS_3UI ||
							(cls == CLS_2UI && half_q)) begin
							state_q  <= HUNT;
							sf_bad_q <= 1'b1;
						end else if (cls == CLS_1UI && !half_q) begin
							half_q <= 1'b1;
						end else begin
							half_q    <= 1'b0;
							data_q    <= data_d;
							bit_idx_q <= bit_idx_q + 5'h01;
							if (bit_idx_q == SF_BITS_LAST) begin
								// even parity over the 28 bits after the preamble
								sf_ok_q     <= ~^data_d;
								sf_bad_q    <= ^data_d;
								sf_q        <= {data_d[AUDIO_W-1:0], left_q,
									block_q, data_d[SF_CS_POS]};
								state_q     <= PREAMBLE;
								pre_sum_q   <= '0;
								pre_first_q <= 1'b1;
							end
						end
					end
				end
				default: state_q <= HUNT;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// channel status word length capture
	// ------------------------------------------------------------------
	logic [7:0] cs_idx_q;
	logic [3:0] cs_field_q;
	logic [7:0] cs_idx_d;

	assign cs_idx_d = sf_q.block_start ? 8'h00 :
		(cs_idx_q == CS_IDX_MAX ? cs_idx_q : cs_idx_q + 8'h01);

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cs_idx_q   <= CS_IDX_MAX;
			cs_field_q <= '0;
		end else if (sf_ok_q && sf_q.left) begin
			cs_idx_q <= cs_idx_d;
			if (cs_idx_d >= CS_WLEN_LO && cs_idx_d <= CS_WLEN_HI)
				cs_field_q[cs_idx_d[1:0]] <= sf_q.chan_stat;
		end
	end

	// ------------------------------------------------------------------
	// lock and recovered frame clock
	// ------------------------------------------------------------------
	ctrl_s ctrl_q;
	logic  locked;
	logic  lock_gained;
	logic  lock_lost;
	wlen_e eff_wlen;

	lock_qualifier u_lock (
		.clock      (CLOCK),
		.resetn     (RESETN),
		.sample_ok  (sf_ok_q),
		.sample_bad (sf_bad_q),
		.fast       (ctrl_q.fast_acquire_select),
		.locked     (locked),
		.gained     (lock_gained),
		.lost       (lock_lost)
	);

	frame_clock_gen u_fclk (
		.clock        (CLOCK),
		.resetn       (RESETN),
		.locked       (locked),
		.stop_on_loss (ctrl_q.loss_behaviour_select),
		.sf_start     (sf_start_q),
		.sf_left      (left_q),
		.fclk         (FRAME_CLK)
	);

	assign eff_wlen = (ctrl_q.word_length_select == WLEN_AUTO) ?
		cs_wlen(cs_field_q) : ctrl_q.word_length_select;

	// ------------------------------------------------------------------
	// mute and restart
	// ------------------------------------------------------------------
	logic restart_q;
	logic restart_prev_q;
	logic auto_q;
	logic lost_flag_q;
	logic restart_fall;
	logic mute_q;

	assign restart_fall = restart_prev_q & ~restart_q;

	// a loss in the same cycle as a restart wins, so no loss is missed
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			restart_prev_q <= 1'b0;
			lost_flag_q    <= 1'b0;
		end else begin
			restart_prev_q <= restart_q;
			if (lock_lost)
				lost_flag_q <= 1'b1;
			else if (locked && (auto_q || restart_fall))
				lost_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			mute_q <= 1'b1;
		else
			mute_q <= ~locked | lost_flag_q | lock_lost;
	end

	// ------------------------------------------------------------------
	// audio output
	// ------------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			AUDIO_DATA   <= '0;
			AUDIO_LEFT   <= 1'b0;
			AUDIO_STROBE <= 1'b0;
		end else begin
			AUDIO_STROBE <= sf_ok_q & locked;
			if (sf_ok_q && locked)
				AUDIO_LEFT <= sf_q.left;
			if (mute_q || (sf_ok_q && locked))
				AUDIO_DATA <= mute_q ? '0 : trim(sf_q.audio, eff_wlen);
		end
	end

	assign AUDIO_MUTE  = mute_q;
	assign WORD_LENGTH = eff_wlen;

	// ------------------------------------------------------------------
	// register slave: one wait cycle, then the answer
	// ------------------------------------------------------------------
	logic             ack_q;
	logic             wr_go;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [31:0]      rd_d;

	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign wr_go = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			ack_q <= 1'b0;
		else
			ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_q     <= ctrl_s'(CTRL_RESET);
			restart_q  <= 1'b0;
			auto_q     <= 1'b0;
			irq_mask_q <= '0;
		end else if (wr_go) begin
			if (hit(AVS_ADDRESS, IDX_CTRL))
				ctrl_q <= ctrl_s'(AVS_WRITEDATA[CTRL_W-1:0]);
			if (hit(AVS_ADDRESS, IDX_RESTART)) begin
				restart_q <= AVS_WRITEDATA[RST_GO_BIT];
				auto_q    <= AVS_WRITEDATA[RST_AUTO_BIT];
			end
			if (hit(AVS_ADDRESS, IDX_IRQ_MASK))
				irq_mask_q <= AVS_WRITEDATA[IRQ_W-1:0];
		end
	end

	// sticky events, write one to clear, a new event wins over the clear
	assign irq_set = {lock_lost, lock_gained};
	assign irq_clr = (wr_go && hit(AVS_ADDRESS, IDX_IRQ_STAT)) ?
		AVS_WRITEDATA[IRQ_W-1:0] : '0;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
	end

	assign IRQ = |(irq_stat_q & irq_mask_q);

	always_comb begin
		rd_d = '0;
		if (hit(AVS_ADDRESS, IDX_LOCK))
			rd_d[LOCK_BIT] = locked;
		else if (hit(AVS_ADDRESS, IDX_CTRL))
			rd_d[CTRL_W-1:0] = ctrl_q;
		else if (hit(AVS_ADDRESS, IDX_RESTART)) begin
			rd_d[RST_GO_BIT]   = restart_q;
			rd_d[RST_AUTO_BIT] = auto_q;
			rd_d[RST_LOST_BIT] = lost_flag_q;
		end else if (hit(AVS_ADDRESS, IDX_IRQ_STAT))
			rd_d[IRQ_W-1:0] = irq_stat_q;
		else if (hit(AVS_ADDRESS, IDX_IRQ_MASK))
			rd_d[IRQ_W-1:0] = irq_mask_q;
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			AVS_READDATA <= '0;
		else if (AVS_READ && !ack_q)
			AVS_READDATA <= rd_d;
	end
endmodule

//--- spdif_rx_lock_sva.sv
// assertion checker for the receiver lock and control block
`timescale 1ns/1ps
module spdif_rx_lock_sva
	import spdif_lock_pkg::*;
(
	input wire logic               CLOCK,
	input wire logic               RESETN,
	input wire logic [ADDR_W-1:0]  AVS_ADDRESS,
	input wire logic               AVS_READ,
	input wire logic               AVS_WRITE,
	input wire logic [31:0]        AVS_WRITEDATA,
	input wire logic [3:0]         AVS_BYTEENABLE,
	input wire logic [31:0]        AVS_READDATA,
	input wire logic               AVS_WAITREQUEST,
	input wire logic               FRAME_CLK,
	input wire logic [AUDIO_W-1:0] AUDIO_DATA,
	input wire logic               AUDIO_STROBE,
	input wire logic               AUDIO_MUTE,
	input wire logic [1:0]         WORD_LENGTH
);
	localparam logic [ADDR_W-1:0] A_LOCK = ADDR_W'({IDX_LOCK, 2'h0});
	localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({IDX_CTRL, 2'h0});
	logic        rd_ok;
	logic        wr_ctrl;
	logic        stop_q;
	logic [13:0] cyc_q;
	logic [10:0] run_q;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
	assign wr_ctrl = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
		&& AVS_ADDRESS == A_CTRL;

	// shadow of the loss behaviour bit, the checker cannot see registers
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			stop_q <= 1'b0;
		else if (wr_ctrl)
			stop_q <= AVS_WRITEDATA[2];
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			cyc_q <= 14'h0;
		else if (cyc_q != 14'h3FFF)
			cyc_q <= cyc_q + 14'h1;
	end

	// cycles since a loss in run mode with no frame clock edge seen yet
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			run_q <= 11'h000;
		else if (!stop_q && $rose(AUDIO_MUTE))
			run_q <= 11'h001;
		else if ($changed(FRAME_CLK))
			run_q <= 11'h000;
		else if (run_q != 11'h000 && run_q != 11'h7FF)
			run_q <= run_q + 11'h001;
	end

	AST_RD_WAIT: assert property (
		$rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
		else $error("read not answered after one wait cycle");
	AST_LOCK_RSVD: assert property (
		rd_ok && AVS_ADDRESS == A_LOCK |-> AVS_READDATA[31:1] == 31'h0)
		else $error("lock status upper bits not zero");
	AST_CTRL_RSVD: assert property (
		rd_ok && AVS_ADDRESS == A_CTRL |-> AVS_READDATA[31:4] == 28'h0)
		else $error("control upper bits not zero");
	AST_WLEN: assert property (
		wr_ctrl && AVS_WRITEDATA[1:0] != 2'h3
		|=> WORD_LENGTH == $past(AVS_WRITEDATA[1:0]))
		else $error("word length does not follow control");
	AST_MUTE_ZERO: assert property (
		AUDIO_MUTE && $past(AUDIO_MUTE) |-> AUDIO_DATA == '0)
		else $error("audio not zero while muted");
	AST_STOP: assert property (
		stop_q && $rose(AUDIO_MUTE) |-> ##[0:4] (!FRAME_CLK [*8]))
		else $error("frame clock not stopped on loss");
	AST_RUN: assert property (
		run_q <= 11'h44C)
		else $error("frame clock not kept running on loss");
	AST_FAST_MIN: assert property (
		AUDIO_STROBE |-> cyc_q > 14'h1B58)
		else $error("sample strobed before any lock was possible");
endmodule

bind spdif_rx_lock spdif_rx_lock_sva chk (.CLOCK, .RESETN, .AVS_ADDRESS,
	.AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
	.AVS_WAITREQUEST, .FRAME_CLK, .AUDIO_DATA, .AUDIO_STROBE, .AUDIO_MUTE,
	.WORD_LENGTH);

//--- spdif_tx_model.sv
// biphase-mark transmitter standing in for the far end of the link
`timescale 1ns/1ps
module spdif_tx_model
	import spdif_lock_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               run,
	input  wire logic [AUDIO_W-1:0] sample,
	output logic                    line,
	output int                      sf_cnt
);
	int          ivs[$];
	int          fi;
	int          k;
	logic        lft;
	logic        first;
	logic [15:0] pre;
	logic [27:0] w;

	// a stopped transmitter holds its level, so the receiver sees a dead line
	initial begin
		line = 1'b0;
		sf_cnt = 0;
		forever begin
			if (!run) begin
				first = 1'b1;
				fi = 0;
				lft = 1'b1;
				@(posedge clock);
			end else begin
				pre = !lft ? 16'h3212 : (fi == 0) ? 16'h3113 : 16'h3311;
				w = {1'b0, lft && fi == 33, 2'h0, sample};
				w[27] = ^w[26:0];
				ivs.delete();
				for (k = 0; k < 4; k++)
					ivs.push_back(int'(pre[15-4*k -: 4]));
				for (k = 0; k < SF_W; k++) begin
					if (w[k]) begin
						ivs.push_back(1);
						ivs.push_back(1);
					end else
						ivs.push_back(2);
				end
				// the previous subframe only ends at this first toggle
				foreach (ivs[j]) begin
					if (j == 0 && !first)
						sf_cnt++;
					line <= ~line;
					repeat (ivs[j] * UI_CYC) @(posedge clock);
				end
				first = 1'b0;
				fi = lft ? fi : (fi + 1) % 192;
				lft = ~lft;
			end
		end
	end
endmodule

//--- tb.sv
// self-checking bench for the receiver lock and control block
`timescale 1ns/1ps
module tb;
	import spdif_lock_pkg::*;
	logic               clock, resetn, avs_rd, avs_wr, run, want, aleft, lft;
	logic [ADDR_W-1:0]  addr;
	logic [31:0]        wdata, rdata;
	logic [3:0]         be;
	logic               waitreq, fclk, strobe, mute, irq, line;
	logic [AUDIO_W-1:0] adata, smp;
	logic [1:0]         wlen;
	logic [31:0]        exp_q[$];
	int                 sf_cnt, bad_count, num_checks, b, ch, hi, c;

	spdif_rx_lock DUT (.CLOCK(clock), .RESETN(resetn), .AVS_ADDRESS(addr),
		.AVS_READ(avs_rd), .AVS_WRITE(avs_wr), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .SPDIF_IN(line), .FRAME_CLK(fclk),
		.AUDIO_DATA(adata), .AUDIO_LEFT(aleft), .AUDIO_STROBE(strobe),
		.AUDIO_MUTE(mute), .WORD_LENGTH(wlen), .IRQ(irq));
	spdif_tx_model tx (.clock(clock), .run(run), .sample(smp),
		.line(line), .sf_cnt(sf_cnt));

	// ------------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic stuck;
		bad_count++;
		$display("mismatch at %0t: wait ran out", $time);
		print_verdict();
	endtask

	// request is held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [15:0] idx,
		input logic [31:0] d, input logic [3:0] m);
		int   n;
		@(posedge clock);
		addr <= ADDR_W'({idx, 2'h0});
		avs_rd <= !w;
		avs_wr <= w;
		wdata <= d;
		be <= m;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		avs_rd <= 1'b0;
		avs_wr <= 1'b0;
		// later checks look at outputs only once they have settled
		@(negedge clock);
		if (n >= 20)
			stuck();
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, idx, 32'h0, 4'hF);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d, 4'h1);
	endtask

	task automatic wait_sf(input int n);
		for (int k = 0; k < 90000 && sf_cnt < n; k++)
			@(posedge clock);
		repeat (16) @(posedge clock);
		if (sf_cnt < n)
			stuck();
	endtask

	// the first strobe after a control write may carry an older sample
	task automatic aud(input logic [23:0] m);
		exp_q.push_back({8'h0, smp & m});
		for (int k = 0; k < 3000 && strobe !== 1'b1; k++)
			@(posedge clock);
		// channels alternate, so the next sample is the other one
		lft = ~aleft;
		@(posedge clock);
		want = 1'b1;
		for (int k = 0; k < 3000 && want; k++)
			@(posedge clock);
		if (want)
			stuck();
	endtask

	task automatic fc_count;
		logic p;
		ch = 0;
		hi = 0;
		p = fclk;
		repeat (1500) begin
			@(negedge clock);
			ch += int'(fclk !== p);
			hi += int'(fclk !== 1'b0);
			p = fclk;
		end
	endtask

	always @(negedge clock) begin
		if (avs_rd && waitreq === 1'b0)
			check(rdata, exp_q.pop_front());
		if (want && strobe === 1'b1) begin
			check({8'h0, adata}, exp_q.pop_front());
			check({31'h0, aleft}, {31'h0, lft});
			want = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		{resetn, avs_rd, avs_wr, run, want} = 5'h0;
		{addr, wdata, be, smp} = '0;
		void'($urandom(7652));
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		rd(IDX_LOCK, 32'h0);
		rd(IDX_CTRL, 32'h0);
		wr(IDX_CTRL, 32'hFFFFFFFF);
		rd(IDX_CTRL, 32'hF);
		bus(1'b1, IDX_CTRL, 32'h0, 4'h0);
		rd(IDX_CTRL, 32'hF);
		wr(IDX_CTRL, 32'h0);
		wr(IDX_LOCK, 32'h1);
		rd(IDX_LOCK, 32'h0);
		rd(16'hF602, 32'h0);
		smp <= 24'($urandom);
		run <= 1'b1;
		wait_sf(63);
		rd(IDX_LOCK, 32'h0);
		wait_sf(64);
		rd(IDX_LOCK, 32'h1);
		rd(IDX_IRQ_STAT, 32'h1);
		check(32'(irq), 32'h0);
		wr(IDX_IRQ_MASK, 32'h3);
		check(32'(irq), 32'h1);
		wr(IDX_IRQ_STAT, 32'h1);
		check(32'(irq), 32'h0);
		check(32'(mute), 32'h0);
		for (c = 0; c < 3; c++) begin
			wr(IDX_CTRL, 32'(c));
			check(32'(wlen), 32'(c));
			aud(24'hFFFFFF << (4 * c));
		end
		wait_sf(74);
		wr(IDX_CTRL, 32'h3);
		check(32'(wlen), 32'h2);
		aud(24'hFFFF00);
		wr(IDX_CTRL, 32'h0);
		run <= 1'b0;
		repeat (2100) @(posedge clock);
		rd(IDX_LOCK, 32'h0);
		check(32'(mute), 32'h1);
		check(32'(irq), 32'h1);
		fc_count();
		check(32'(ch > 0), 32'h1);
		wr(IDX_CTRL, 32'h8);
		b = sf_cnt;
		run <= 1'b1;
		wait_sf(b + 7);
		rd(IDX_LOCK, 32'h0);
		wait_sf(b + 8);
		rd(IDX_LOCK, 32'h1);
		check(32'(mute), 32'h1);
		wr(IDX_RESTART, 32'h1);
		wr(IDX_RESTART, 32'h0);
		repeat (4) @(negedge clock);
		check(32'(mute), 32'h0);
		wr(IDX_CTRL, 32'hC);
		run <= 1'b0;
		repeat (2100) @(posedge clock);
		fc_count();
		check(32'(ch + hi), 32'h0);
		print_verdict();
	end
endmodule
